//--- verilog/asp_pkg.sv
`default_nettype none
package asp_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned CONV_TIME_US = 16600;
  localparam int unsigned CONV_CYCLES = CONV_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned SLOW_RATE_FACTOR = 2;
  localparam int unsigned POR_TIME_US = 500;
  localparam int unsigned POR_CYCLES = POR_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W = 23;

  // Result coding
  localparam int unsigned RESULT_W = 16;
  localparam int unsigned SAMPLE_W = 18;
  localparam logic [15:0] CODE_MIN = 16'h0000;
  localparam logic [15:0] CODE_MAX = 16'hFFFF;
  localparam logic signed [17:0] SAMPLE_ZERO = 18'sh00000;
  localparam logic signed [17:0] SAMPLE_TOP = 18'sh0FFFF;
  localparam logic signed [17:0] SAMPLE_MID = 18'sh08000;
  localparam logic signed [17:0] SAMPLE_NEG_MID = -18'sh08000;
  localparam logic [3:0] LAST_FALL = 4'hF;

  // Programming word: enable pair, rate select, reference power-down
  localparam int unsigned PROG_W = 4;
  localparam logic [2:0] PROG_LAST = 3'h3;
  localparam logic [1:0] PROG_ENABLE = 2'h2;
  localparam int unsigned PROG_EN_HI = 3;
  localparam int unsigned PROG_EN_LO = 2;
  localparam int unsigned PROG_RATE_BIT = 1;
  localparam int unsigned PROG_PD_BIT = 0;

  // Reset values
  localparam logic RATE_RESET = 1'b0;
  localparam logic PD_RESET = 1'b0;
  localparam logic REF_ON_RESET = 1'b1;
  localparam logic [2:0] PIN_RESET = 3'h4;

  typedef enum logic [3:0] {
    ST_POR = 4'h1,
    ST_CONV = 4'h2,
    ST_NAP = 4'h4,
    ST_DATA = 4'h8
  } asp_state_t;

endpackage
`default_nettype wire

//--- verilog/asp_sync.sv
`timescale 1ns/100ps
`default_nettype none
module asp_sync #(
  parameter int unsigned WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      logic meta_ff;
      logic stable_ff;
      always_ff @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
        begin
          meta_ff <= RESET_VAL[gi];
          stable_ff <= RESET_VAL[gi];
        end
        else
        begin
          meta_ff <= async_in[gi];
          stable_ff <= meta_ff;
        end
      end
      assign sync_out[gi] = stable_ff;
    end
  endgenerate

endmodule // asp_sync
`default_nettype wire

//--- verilog/asp_result_port.sv
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// [R01] Each result is a 16-bit straight binary code shifted out on sck.
// [R02] Single-ended: below zero gives 0, above reference gives 65535.
// [R03] Differential: clamp to 65535 at or above ref, 0 at or below -ref.
// [R04] Differential code is offset binary, midscale 32768 at zero input.
// [R05] MSB first; differential MSB is 1 when input is non-negative.
// [R06] MSB appears on the data output as soon as chip select falls with sck low.
// [R07] Each falling sck edge advances the output to the next bit.
// [R08] Host holds chip select low and latches bits on rising sck.
// [R09] Programming word is 4 bits: two enables, rate, ref power-down.
// [R10] First enable bit is taken on first rising sck after conversion.
// [R11] Rate and power-down bits accepted only when enables are 1 then 0.
// [R12] Single-ended rate 0 gives 60Hz no calibration; 1 gives 30Hz with.
// [R13] Data input tied low or high selects rate 0 or 1 without transfer.
// [R14] Differential always runs 60Hz with calibration, ignoring rate.
// [R15] Power-down select turns reference off after next conversion.
// [R16] Host waits about 12ms after waking reference or drops first result.
// [R17] Data input tied high disables the reference power-down mode.
// [R18] With sck high and select low, output shows busy high, done low.
// [R19] Conversions take a fixed time, 16.6ms typical, 23ms at most; single-ended rate 1 here takes twice that, 33.2ms.
// [R20] After the sixteenth bit, select high or sck low starts a conversion.
// [R21] Select rising during data output aborts and starts a conversion.
// [R22] Serial clock may idle high or low between transfers.
// [R23] After conversion wait until select is low, then enter data state.
// [R24] Data input bits are sampled on rising sck in the data state.
// [R25] Power-up reset of about 0.5ms clears registers, then converts.
// [R26] Mismatched enable bits leave rate and power-down settings unchanged.
// [R27] Data output is high impedance whenever chip select is high.
module asp_result_port #(
  parameter bit DIFFERENTIAL = 1'b0,
  parameter int unsigned CONV_CYCLES = asp_pkg::CONV_CYCLES,
  parameter int unsigned POR_CYCLES = asp_pkg::POR_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic sck,
  input wire logic sdi,
  input wire logic signed [asp_pkg::SAMPLE_W-1:0] conv_sample,
  output logic sdo_out,
  output logic sdo_oe_b,
  output logic [asp_pkg::RESULT_W-1:0] result_word,
  output logic conv_active,
  output logic conv_start,
  output logic conv_done,
  output logic reference_output_on,
  output logic rate_select,
  output logic ref_powerdown_select,
  output logic bg_cal_enable
);

  localparam logic [asp_pkg::TIMER_W-1:0] POR_LAST =
    asp_pkg::TIMER_W'(POR_CYCLES - 1);
  localparam logic [asp_pkg::TIMER_W-1:0] CONV_LAST_FAST =
    asp_pkg::TIMER_W'(CONV_CYCLES - 1);
  localparam logic [asp_pkg::TIMER_W-1:0] CONV_LAST_SLOW =
    asp_pkg::TIMER_W'(CONV_CYCLES * asp_pkg::SLOW_RATE_FACTOR - 1);

  asp_pkg::asp_state_t state_ff;
  logic [asp_pkg::TIMER_W-1:0] timer_ff;
  logic [2:0] pins_sync;
  logic cs_s;
  logic sck_s;
  logic sdi_s;
  logic cs_q_ff;
  logic sck_q_ff;
  logic sdi_q_ff;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic [asp_pkg::RESULT_W-1:0] result_ff;
  logic [asp_pkg::RESULT_W-1:0] shift_ff;
  logic [3:0] fall_cnt_ff;
  logic hold_first_ff;
  logic [2:0] prog_ff;
  logic [2:0] in_cnt_ff;
  logic [asp_pkg::PROG_W-1:0] prog_word;
  logic rate_ff;
  logic pd_ff;
  logic sdi_toggled_ff;
  logic ref_on_ff;
  logic sdo_ff;
  logic oe_b_ff;
  logic start_ff;
  logic done_ff;
  logic nxt_sdo;
  logic in_data;
  logic enter_data;
  logic last_fall;
  logic timer_done;
  logic conv_finish;
  logic tied;
  logic rate_eff;
  logic pd_eff;

  asp_sync #(
    .WIDTH(3),
    .RESET_VAL(asp_pkg::PIN_RESET)
  ) u_pin_sync (
    .clock(clock),
    .rst_b(rst_b),
    .async_in({cs_b, sck, sdi}),
    .sync_out(pins_sync)
  );

  assign cs_s = pins_sync[2];
  assign sck_s = pins_sync[1];
  assign sdi_s = pins_sync[0];

  // Edge detection runs on the synchronised copies only
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cs_q_ff <= asp_pkg::PIN_RESET[2];
      sck_q_ff <= asp_pkg::PIN_RESET[1];
      sdi_q_ff <= asp_pkg::PIN_RESET[0];
    end
    else
    begin
      cs_q_ff <= cs_s;
      sck_q_ff <= sck_s;
      sdi_q_ff <= sdi_s;
    end
  end

  assign cs_rise = cs_s && !cs_q_ff; // [R21]
  assign sck_rise = sck_s && !sck_q_ff;
  assign sck_fall = !sck_s && sck_q_ff;

  function automatic logic [15:0] asp_code(
    input logic signed [17:0] s
  );
    logic signed [17:0] t;
    t = s + asp_pkg::SAMPLE_MID;
    if (DIFFERENTIAL)
    begin
      if (s >= asp_pkg::SAMPLE_MID)
        return asp_pkg::CODE_MAX; // [R03]
      else if (s <= asp_pkg::SAMPLE_NEG_MID)
        return asp_pkg::CODE_MIN; // [R03]
      else
        return t[15:0]; // [R04] [R05]
    end
    else
    begin
      if (s < asp_pkg::SAMPLE_ZERO)
        return asp_pkg::CODE_MIN; // [R02]
      else if (s > asp_pkg::SAMPLE_TOP)
        return asp_pkg::CODE_MAX; // [R02]
      else
        return s[15:0]; // [R01]
    end
  endfunction

  // Tied data input is inferred from never having seen it toggle
  assign tied = !sdi_toggled_ff;
  assign rate_eff = DIFFERENTIAL ? 1'b0 : (tied ? sdi_s : rate_ff); // [R13]
  assign pd_eff = tied ? 1'b0 : pd_ff; // [R17]

  assign in_data = (state_ff == asp_pkg::ST_DATA);
  assign enter_data = (state_ff == asp_pkg::ST_NAP) && !cs_s; // [R23]
  assign last_fall = in_data && sck_fall && !hold_first_ff &&
    (fall_cnt_ff == asp_pkg::LAST_FALL);
  assign conv_finish = (state_ff == asp_pkg::ST_CONV) && timer_done;
  assign prog_word = {prog_ff, sdi_s};

  always_comb
  begin
    timer_done = 1'b0;
    if (state_ff == asp_pkg::ST_POR)
      timer_done = (timer_ff == POR_LAST); // [R25]
    else if (state_ff == asp_pkg::ST_CONV) // [R12] [R19]
      timer_done = (timer_ff == (rate_eff ? CONV_LAST_SLOW : CONV_LAST_FAST));
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      state_ff <= asp_pkg::ST_POR;
    else
    begin
      case (state_ff)
        asp_pkg::ST_POR: if (timer_done) state_ff <= asp_pkg::ST_CONV; // [R25]
        asp_pkg::ST_CONV: if (timer_done) state_ff <= asp_pkg::ST_NAP;
        asp_pkg::ST_NAP: if (!cs_s) state_ff <= asp_pkg::ST_DATA; // [R23]
        asp_pkg::ST_DATA:
          if (cs_rise || last_fall) state_ff <= asp_pkg::ST_CONV; // [R20]
        default: state_ff <= asp_pkg::ST_POR;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      timer_ff <= '0;
    else if (timer_done || in_data || state_ff == asp_pkg::ST_NAP)
      timer_ff <= '0;
    else
      timer_ff <= timer_ff + 1'b1;
  end

  // Result is frozen at the end of each conversion
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      result_ff <= asp_pkg::CODE_MIN;
    else if (conv_finish)
      result_ff <= asp_code(conv_sample); // [R01]
  end

  // Output shifter; with sck high on entry the first fall only exposes MSB
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shift_ff <= '0;
      fall_cnt_ff <= '0;
      hold_first_ff <= 1'b0;
    end
    else if (enter_data)
    begin
      shift_ff <= result_ff; // [R06]
      fall_cnt_ff <= '0;
      hold_first_ff <= sck_s; // [R22]
    end
    else if (in_data && sck_fall)
    begin
      if (hold_first_ff)
        hold_first_ff <= 1'b0;
      else
      begin
        shift_ff <= {shift_ff[asp_pkg::RESULT_W-2:0], 1'b0}; // [R07]
        fall_cnt_ff <= fall_cnt_ff + 1'b1;
      end
    end
  end

  // Programming word capture; applied on the fourth rising edge
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prog_ff <= '0;
      in_cnt_ff <= '0;
      rate_ff <= asp_pkg::RATE_RESET;
      pd_ff <= asp_pkg::PD_RESET;
    end
    else if (enter_data)
    begin
      prog_ff <= '0;
      in_cnt_ff <= '0;
    end
    else if (in_data && sck_rise && in_cnt_ff <= asp_pkg::PROG_LAST)
    begin
      prog_ff <= prog_word[2:0]; // [R24]
      in_cnt_ff <= in_cnt_ff + 1'b1; // [R10]
      if (in_cnt_ff == asp_pkg::PROG_LAST &&
          prog_word[asp_pkg::PROG_EN_HI:asp_pkg::PROG_EN_LO] ==
          asp_pkg::PROG_ENABLE) // [R09] [R11] [R26]
      begin
        rate_ff <= prog_word[asp_pkg::PROG_RATE_BIT];
        pd_ff <= prog_word[asp_pkg::PROG_PD_BIT];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      sdi_toggled_ff <= 1'b0;
    else if (state_ff != asp_pkg::ST_POR && sdi_s != sdi_q_ff)
      sdi_toggled_ff <= 1'b1;
  end

  // Select low wakes the reference even if a conversion ends then
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      ref_on_ff <= asp_pkg::REF_ON_RESET;
    else if (!cs_s)
      ref_on_ff <= 1'b1;
    else if (conv_finish && pd_eff)
      ref_on_ff <= 1'b0; // [R15]
  end

  always_comb
  begin
    nxt_sdo = 1'b0;
    case (state_ff)
      asp_pkg::ST_POR, asp_pkg::ST_CONV: nxt_sdo = 1'b1; // [R18]
      asp_pkg::ST_DATA: nxt_sdo = hold_first_ff ? 1'b0 : shift_ff[15]; // [R05]
      default: nxt_sdo = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sdo_ff <= 1'b0;
      oe_b_ff <= 1'b1;
    end
    else
    begin
      sdo_ff <= enter_data ? result_ff[15] && !sck_s : nxt_sdo; // [R06]
      oe_b_ff <= cs_s; // [R27]
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      start_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      start_ff <= (in_data && (cs_rise || last_fall)) ||
        (state_ff == asp_pkg::ST_POR && timer_done);
      done_ff <= conv_finish;
    end
  end

  assign sdo_out = sdo_ff;
  assign sdo_oe_b = oe_b_ff;
  assign result_word = result_ff;
  assign conv_active = (state_ff == asp_pkg::ST_CONV);
  assign conv_start = start_ff;
  assign conv_done = done_ff;
  assign reference_output_on = ref_on_ff;
  assign rate_select = rate_ff;
  assign ref_powerdown_select = pd_ff;
  assign bg_cal_enable = DIFFERENTIAL ? 1'b1 : rate_eff; // [R12] [R14]
endmodule // asp_result_port
`default_nettype wire

//--- test/asp_result_port_checker.sv
`timescale 1ns/100ps
`default_nettype none
module asp_result_port_checker (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic sck,
  input wire logic sdo_out,
  input wire logic sdo_oe_b,
  input wire logic [asp_pkg::RESULT_W-1:0] result_word,
  input wire logic conv_active,
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic reference_output_on,
  input wire logic rate_select,
  input wire logic ref_powerdown_select
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_hiz; cs_b [*5] |-> sdo_oe_b; endproperty
  a_hiz: assert property (p_hiz) else $error("sdo driven");
  property p_wake; !sdo_oe_b [*3] |-> reference_output_on; endproperty
  a_wake: assert property (p_wake) else $error("ref off");
  property p_pd;
    $fell(reference_output_on) |-> ref_powerdown_select && sdo_oe_b;
  endproperty
  a_pd: assert property (p_pd) else $error("ref dropped");
  property p_start; conv_start |-> ##[0:1] conv_active; endproperty
  a_start: assert property (p_start) else $error("no conv");
  property p_done; conv_done |-> ##[0:1] !conv_active; endproperty
  a_done: assert property (p_done) else $error("still conv");
  property p_len; $rose(conv_active) |-> conv_active [*8]; endproperty
  a_len: assert property (p_len) else $error("conv short");
  property p_hold;
    conv_active && $past(conv_active) |-> $stable(result_word);
  endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  property p_cfg;
    conv_active && $past(conv_active) |->
      $stable(rate_select) && $stable(ref_powerdown_select);
  endproperty
  a_cfg: assert property (p_cfg) else $error("cfg moved");
  property p_msb;
    $fell(sdo_oe_b) && !conv_active && !sck |->
      ##[0:2] sdo_out == result_word[15];
  endproperty
  a_msb: assert property (p_msb) else $error("msb");
  property p_busy;
    conv_active && $past(conv_active, 3) && !sdo_oe_b && !$past(sdo_oe_b)
      |-> sdo_out;
  endproperty
  a_busy: assert property (p_busy) else $error("busy low");
endmodule // asp_result_port_checker
bind asp_result_port asp_result_port_checker chk (.clock, .rst_b, .cs_b,
  .sck, .sdo_out, .sdo_oe_b, .result_word, .conv_active, .conv_start,
  .conv_done, .reference_output_on, .rate_select, .ref_powerdown_select);
`default_nettype wire

//--- test/asp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module asp_host_model (
  input wire logic clock,
  input wire logic sdo_out,
  input wire logic sdo_oe_b,
  output logic cs_b,
  output logic sck,
  output logic sdi
);
  logic flip = 1'b0;
  // No pull on the line: a released output must not look like data
  always @(posedge clock) flip <= ~flip;
  initial
  begin
    cs_b = 1'b1;
    sck = 1'b0;
    sdi = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic xfer(input logic [15:0] din, input int nbits,
    input logic hi, output logic stat, output logic [15:0] got);
    sck <= hi;
    tick(2);
    cs_b <= 1'b0;
    tick(8);
    stat = sdo_oe_b ? flip : sdo_out;
    got = '0;
    for (int k = 0; k < nbits; k++)
    begin
      sck <= 1'b0;
      sdi <= din[15 - k];
      tick(5);
      sck <= 1'b1;
      got = {got[14:0], sdo_oe_b ? flip : sdo_out};
      tick(5);
    end
    if (!hi)
      sck <= 1'b0;
    tick(5);
    cs_b <= 1'b1;
    tick(4);
  endtask
endmodule // asp_host_model
`default_nettype wire

//--- test/asp_result_port_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define ASP_CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module asp_result_port_bench;
  localparam int unsigned CONV = 200;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic signed [17:0] conv_sample;
  logic cs_b, sck, sdi, sdo_out, sdo_oe_b;
  logic [15:0] result_word;
  logic conv_active, conv_start, conv_done, ref_on, rate_sel, pd_sel, bg_cal;
  logic signed [17:0] diff_sample;
  logic [15:0] diff_word;
  logic diff_cal;
  int checked = 0;
  int bad_count = 0;
  int seed = 31787;
  int smp[$] = '{-5, 70000, 32768, 65535, 0, 0, 0};
  logic [15:0] din[6] = '{16'hF0F0, 16'hA000, 16'h6FFF, 16'h9000,
    16'h8000, 16'h8000};
  int nb[6] = '{16, 16, 16, 5, 16, 16};
  logic m_rate = 1'b0;
  logic m_pd = 1'b0;
  always #4 clock = ~clock;
  asp_result_port #(.DIFFERENTIAL(1'b0), .CONV_CYCLES(CONV),
    .POR_CYCLES(20)) uut (.clock(clock), .rst_b(rst_b), .cs_b(cs_b),
    .sck(sck), .sdi(sdi), .conv_sample(conv_sample), .sdo_out(sdo_out),
    .sdo_oe_b(sdo_oe_b), .result_word(result_word),
    .conv_active(conv_active), .conv_start(conv_start),
    .conv_done(conv_done), .reference_output_on(ref_on),
    .rate_select(rate_sel), .ref_powerdown_select(pd_sel),
    .bg_cal_enable(bg_cal));
  asp_host_model host (.clock(clock), .sdo_out(sdo_out),
    .sdo_oe_b(sdo_oe_b), .cs_b(cs_b), .sck(sck), .sdi(sdi));
  // Differential twin shares the pins; it is never slower than uut
  asp_result_port #(.DIFFERENTIAL(1'b1), .CONV_CYCLES(CONV),
    .POR_CYCLES(20)) uut_diff (.clock(clock), .rst_b(rst_b), .cs_b(cs_b),
    .sck(sck), .sdi(sdi), .conv_sample(diff_sample), .sdo_out(),
    .sdo_oe_b(), .result_word(diff_word), .conv_active(),
    .conv_start(), .conv_done(), .reference_output_on(),
    .rate_select(), .ref_powerdown_select(), .bg_cal_enable(diff_cal));
  task automatic summarize();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_done(output int n);
    n = 0;
    while (conv_done !== 1'b1)
    begin
      @(posedge clock);
      #1;
      n++;
      if (n > 3000)
      begin
        bad_count++;
        summarize();
      end
    end
    repeat (3) @(posedge clock);
  endtask
  function automatic int clamp(int s);
    return s < 0 ? 0 : (s > 65535 ? 65535 : s);
  endfunction
  function automatic int dcode(int d);
    return d >= 32768 ? 65535 : (d <= -32768 ? 0 : d + 32768);
  endfunction
  initial
  begin
    int n;
    logic st;
    logic [15:0] got, e;
    smp[4] = $random(seed) & 32'hFFFF;
    smp[5] = $random(seed) & 32'hFFFF;
    conv_sample = 18'(smp[0]);
    diff_sample = 18'(smp[0] - 32768);
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    // Sdi held high since reset selects the slow rate
    wait_done(n);
    `ASP_CHK(n > 300, 1'b1)
    `ASP_CHK(bg_cal, 1'b1)
    for (int i = 0; i < 6; i++)
    begin
      e = 16'(clamp(smp[i]));
      `ASP_CHK(ref_on, !m_pd)
      host.xfer(din[i], nb[i], i[0], st, got);
      `ASP_CHK(st, i[0] ? 1'b0 : e[15])
      `ASP_CHK(got, e >> (16 - nb[i]))
      `ASP_CHK(result_word, e)
      `ASP_CHK(diff_word, 16'(dcode(smp[i] - 32768)))
      `ASP_CHK(ref_on, 1'b1)
      if (din[i][15:14] == 2'b10)
      begin
        m_rate = din[i][13];
        m_pd = din[i][12];
      end
      @(posedge clock);
      conv_sample <= 18'(smp[i + 1]);
      diff_sample <= 18'(smp[i + 1] - 32768);
      wait_done(n);
      `ASP_CHK(n > 300, m_rate)
      `ASP_CHK(rate_sel, m_rate)
      `ASP_CHK(bg_cal, m_rate)
      `ASP_CHK(pd_sel, m_pd)
      `ASP_CHK(diff_cal, 1'b1)
    end
    summarize();
  end
endmodule // asp_result_port_bench
`default_nettype wire
